/* File: core/crd_device.sv */
// Device end: frames link requests onto the request stream, forwards
// completions from user logic toward the link.
// What this block does
// RQ1 - Map link requests onto request stream transfers.
// RQ2 - Both channels share width 64, 128 or 256.
// RQ3 - Accept user completions and forward to link.
// RQ4 - Request and completion channels run independently.
// RQ5 - Each request is its own stream packet.
// RQ6 - Descriptor fills exactly the first 16 bytes.
// RQ7 - Two beats at 64 bits, else one.
// RQ8 - Descriptor layout chosen by request class.
// RQ9 - Bits 1:0 carry address type bits.
// RQ10 - Bits 63:2 carry Dword address; user adds enables.
// RQ11 - Short addresses zero upper bits 63:32.
// RQ12 - Bits 74:64 hold Dword count, 0 to 256.
// RQ13 - I/O requests report Dword count of one.
// RQ14 - Zero-length access: count one, no byte enables.
// RQ15 - Bits 78:75 carry the request type.
// RQ16 - Bits 95:80 carry the requester identifier.
// RQ17 - User keeps requester id for its completion.
// RQ18 - Bits 103:96 carry tag, returned for non-posted.
// RQ19 - Non-posted needs credit; posted keep flowing.
// RQ20 - Bits 114:112 carry the matching region number.
// RQ21 - Undefined descriptor bits are driven zero.
// RQ22 - Payload follows descriptor; last beat marked.
`timescale 1ns/1ns
`default_nettype none
module crd_device #(
  parameter int DW = 64
) (
  input wire logic clock,
  input wire logic rst_b,
  crd_if.device bus,
  input wire logic hdr_p_valid,
  input wire crd_pkg::crd_hdr_s hdr_p,
  output logic hdr_p_ready,
  input wire logic hdr_np_valid,
  input wire crd_pkg::crd_hdr_s hdr_np,
  output logic hdr_np_ready,
  input wire logic pay_valid,
  input wire logic [DW-1:0] pay_data,
  input wire logic pay_last,
  output logic pay_ready,
  output logic pay_from_np,
  output logic cpl_valid,
  output logic [DW-1:0] cpl_data,
  output logic cpl_last,
  input wire logic cpl_ready
);
  localparam logic [1:0] DESC_BEATS = crd_pkg::desc_beats(DW); // RQ7
  localparam logic [crd_pkg::CRED_W-1:0] CRED_MAX = '1;
  localparam logic [crd_pkg::CRED_W-1:0] CRED_ONE =
    {{(crd_pkg::CRED_W-1){1'b0}}, 1'b1};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DESC = 2'b01,
    ST_PAY = 2'b10
  } crd_state_e;

  crd_state_e state;
  logic [crd_pkg::CRED_W-1:0] credit;
  logic [crd_pkg::DESC_W-1:0] desc;
  logic [crd_pkg::DESC_W-1:0] built_desc;
  logic [crd_pkg::FBE_W-1:0] built_fbe;
  logic [crd_pkg::FBE_W-1:0] fbe;
  logic has_pay;
  logic [1:0] beat;
  logic take_p;
  logic take_np;
  logic take;
  logic can_load;
  logic desc_done;
  logic [DW-1:0] desc_word;
  crd_pkg::crd_hdr_s sel_hdr;

  // ----------------------------------------------------------------------
  // Request selection and credit
  // ----------------------------------------------------------------------
  // Posted traffic is never held back by a lack of non-posted credit.
  assign take_p = (state == ST_IDLE) && hdr_p_valid; // RQ19
  assign take_np = (state == ST_IDLE) && !hdr_p_valid && hdr_np_valid
                   && (credit != '0); // RQ19
  assign take = take_p || take_np;
  assign hdr_p_ready = take_p;
  assign hdr_np_ready = take_np;
  assign sel_hdr = take_p ? hdr_p : hdr_np;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      credit <= '0;
    end else begin
      // A grant in the same cycle as a delivery leaves the count unchanged.
      if (bus.nonposted_credit_grant && !take_np && credit != CRED_MAX) begin
        credit <= credit + CRED_ONE; // RQ19
      end else if (take_np && !bus.nonposted_credit_grant) begin
        credit <= credit - CRED_ONE; // RQ19
      end
    end
  end

  crd_desc_build u_build (
    .hdr(sel_hdr),
    .desc(built_desc),
    .fbe(built_fbe)
  ); // RQ8

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      desc <= '0;
      fbe <= '0;
      has_pay <= 1'b0;
      pay_from_np <= 1'b0;
    end else if (take) begin
      desc <= built_desc;
      fbe <= built_fbe;
      has_pay <= sel_hdr.has_pay;
      pay_from_np <= take_np;
    end
  end

  // ----------------------------------------------------------------------
  // Request stream framing
  // ----------------------------------------------------------------------
  // The output stage is one register deep; it reloads whenever empty or
  // drained, so a stall on the stream stalls both descriptor and payload.
  assign can_load = !bus.creq_tvalid || bus.creq_tready;
  assign desc_done = (beat == DESC_BEATS - 2'h1);
  assign pay_ready = (state == ST_PAY) && can_load; // RQ22

  // A wide stream carries the whole descriptor, zero-extended; a narrow
  // one sends the upper half on its second beat. Casts keep every width.
  always_comb begin
    desc_word = DW'(desc); // RQ6
    if (beat[0]) begin
      desc_word = DW'(desc >> DW); // RQ7
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      beat <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          beat <= '0;
          if (take) begin
            state <= ST_DESC; // RQ5
          end
        end
        ST_DESC: begin
          if (can_load) begin
            if (desc_done) begin
              state <= has_pay ? ST_PAY : ST_IDLE; // RQ22
            end else begin
              beat <= beat + 2'h1;
            end
          end
        end
        ST_PAY: begin
          if (pay_valid && pay_ready && pay_last) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus.creq_tvalid <= 1'b0;
      bus.creq_tlast <= 1'b0;
      bus.creq_tdata <= '0;
      bus.request_channel_sideband <= '0;
    end else if (can_load) begin
      if (state == ST_DESC) begin
        bus.creq_tvalid <= 1'b1; // RQ1
        bus.creq_tdata <= desc_word; // RQ6
        bus.creq_tlast <= desc_done && !has_pay; // RQ5
        bus.request_channel_sideband <= fbe; // RQ10
      end else if (state == ST_PAY && pay_valid) begin
        bus.creq_tvalid <= 1'b1;
        bus.creq_tdata <= pay_data; // RQ22
        bus.creq_tlast <= pay_last; // RQ22
      end else begin
        bus.creq_tvalid <= 1'b0;
        bus.creq_tlast <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Completion forwarding
  // ----------------------------------------------------------------------
  // This path shares no state with the request framer above.
  assign bus.ccpl_tready = !cpl_valid || cpl_ready; // RQ4

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cpl_valid <= 1'b0;
      cpl_data <= '0;
      cpl_last <= 1'b0;
    end else if (bus.ccpl_tready) begin
      cpl_valid <= bus.ccpl_tvalid; // RQ3
      if (bus.ccpl_tvalid) begin
        cpl_data <= bus.ccpl_tdata; // RQ3
        cpl_last <= bus.ccpl_tlast;
      end
    end
  end
endmodule : crd_device
`default_nettype wire

/* File: core/crd_pkg.sv */
// Shared constants, field layout and types of the completer request path.
package crd_pkg;
  // ----------------------------------------------------------------------
  // Descriptor layout
  // ----------------------------------------------------------------------
  localparam int DESC_W = 128;
  localparam int AT_LSB = 0;
  localparam int AT_W = 2;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 63;
  localparam int ADDR_HI_LSB = 32;
  localparam int CNT_LSB = 64;
  localparam int CNT_W = 11;
  localparam int TYPE_LSB = 75;
  localparam int TYPE_W = 4;
  localparam int RID_LSB = 80;
  localparam int RID_W = 16;
  localparam int TAG_LSB = 96;
  localparam int TAG_W = 8;
  localparam int BAR_LSB = 112;
  localparam int BAR_W = 3;
  localparam int FBE_W = 4;
  localparam int NARROW_DW = 64;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [FBE_W-1:0] FBE_NONE = 4'h0;
  localparam logic [AT_W-1:0] AT_UNTRANSLATED = 2'h0;
  localparam logic [AT_W-1:0] AT_TRANS_REQ = 2'h1;
  localparam logic [AT_W-1:0] AT_TRANSLATED = 2'h2;
  // ----------------------------------------------------------------------
  // Completion beat layout (single beat, user to device)
  // ----------------------------------------------------------------------
  localparam int CPL_TAG_LSB = 0;
  localparam int CPL_RID_LSB = 8;
  localparam int CPL_DATA_LSB = 32;
  localparam int CPL_DATA_W = 32;
  localparam int CRED_W = 6;

  typedef enum logic [1:0] {
    CLS_MEM = 2'b00,
    CLS_VDM = 2'b01,
    CLS_ATS = 2'b10,
    CLS_MSG = 2'b11
  } crd_class_e;

  typedef struct packed {
    crd_class_e cls;
    logic io;
    logic posted;
    logic has_pay;
    logic addr64;
    logic zero_len;
    logic [AT_W-1:0] at;
    logic [63:0] addr;
    logic [CNT_W-1:0] len;
    logic [TYPE_W-1:0] rtype;
    logic [RID_W-1:0] rid;
    logic [TAG_W-1:0] tag;
    logic [BAR_W-1:0] bar;
    logic [FBE_W-1:0] fbe;
  } crd_hdr_s;

  // Beats the descriptor takes at a given stream width.
  function automatic logic [1:0] desc_beats(input int dw);
    desc_beats = (dw == NARROW_DW) ? 2'h2 : 2'h1;
  endfunction : desc_beats
endpackage : crd_pkg

/* File: core/crd_if.sv */
// Interface joining the device end and the user end of the completer path.
`timescale 1ns/1ns
`default_nettype none
interface crd_if #(parameter int DW = 64);
  logic creq_tvalid;
  logic creq_tready;
  logic creq_tlast;
  logic [DW-1:0] creq_tdata;
  logic [crd_pkg::FBE_W-1:0] request_channel_sideband;
  logic nonposted_credit_grant;
  logic ccpl_tvalid;
  logic ccpl_tready;
  logic ccpl_tlast;
  logic [DW-1:0] ccpl_tdata;

  modport device (
    output creq_tvalid, creq_tlast, creq_tdata, request_channel_sideband,
    input creq_tready, nonposted_credit_grant,
    input ccpl_tvalid, ccpl_tlast, ccpl_tdata,
    output ccpl_tready
  );
  modport user (
    input creq_tvalid, creq_tlast, creq_tdata, request_channel_sideband,
    output creq_tready, nonposted_credit_grant,
    output ccpl_tvalid, ccpl_tlast, ccpl_tdata,
    input ccpl_tready
  );
endinterface : crd_if
`default_nettype wire

/* File: core/crd_desc_build.sv */
// Builds the 16-byte request descriptor from a decoded request header.
`timescale 1ns/1ns
`default_nettype none
module crd_desc_build (
  input wire crd_pkg::crd_hdr_s hdr,
  output logic [crd_pkg::DESC_W-1:0] desc,
  output logic [crd_pkg::FBE_W-1:0] fbe
);
  logic addr_cls;
  logic [63:0] addr;

  assign addr_cls = (hdr.cls == crd_pkg::CLS_MEM);
  // Upper address half is forced low for short-address requests.
  assign addr = hdr.addr64 ? hdr.addr : {32'h0, hdr.addr[31:0]}; // RQ11

  always_comb begin
    desc = '0; // RQ21
    if (addr_cls) begin
      if (!hdr.io) begin
        desc[crd_pkg::AT_LSB +: crd_pkg::AT_W] = hdr.at; // RQ9
      end
      desc[crd_pkg::ADDR_MSB:crd_pkg::ADDR_LSB] =
        addr[crd_pkg::ADDR_MSB:crd_pkg::ADDR_LSB]; // RQ10
      desc[crd_pkg::BAR_LSB +: crd_pkg::BAR_W] = hdr.bar; // RQ20
    end
    if (addr_cls && (hdr.io || hdr.zero_len)) begin
      desc[crd_pkg::CNT_LSB +: crd_pkg::CNT_W] = crd_pkg::CNT_ONE; // RQ13
    end else begin
      desc[crd_pkg::CNT_LSB +: crd_pkg::CNT_W] = hdr.len; // RQ12
    end
    desc[crd_pkg::TYPE_LSB +: crd_pkg::TYPE_W] = hdr.rtype; // RQ15
    desc[crd_pkg::RID_LSB +: crd_pkg::RID_W] = hdr.rid; // RQ16
    desc[crd_pkg::TAG_LSB +: crd_pkg::TAG_W] = hdr.tag; // RQ18
  end

  // A zero-length access carries no enabled byte.
  assign fbe = (addr_cls && hdr.zero_len) ? crd_pkg::FBE_NONE : hdr.fbe; // RQ14
endmodule : crd_desc_build
`default_nettype wire

/* File: core/crd_user.sv */
// User end: unpacks request descriptors, grants non-posted credit and
// returns completions carrying the stored requester id and tag.
`timescale 1ns/1ns
`default_nettype none
module crd_user #(
  parameter int DW = 64
) (
  input wire logic clock,
  input wire logic rst_b,
  crd_if.user bus,
  output logic rq_valid,
  output logic [crd_pkg::DESC_W-1:0] rq_desc,
  output logic [crd_pkg::FBE_W-1:0] rq_fbe,
  input wire logic rq_np,
  input wire logic rq_ready,
  output logic pay_valid,
  output logic [DW-1:0] pay_data,
  output logic pay_last,
  input wire logic pay_ready,
  input wire logic cpl_valid,
  input wire logic [crd_pkg::CPL_DATA_W-1:0] cpl_data,
  output logic cpl_ready
);
  localparam logic [1:0] DESC_BEATS = crd_pkg::desc_beats(DW); // RQ2

  typedef enum logic [1:0] {
    HS_DESC = 2'b00,
    HS_HOLD = 2'b01,
    HS_PAY = 2'b10
  } crd_ustate_e;

  crd_ustate_e state;
  logic [1:0] beat;
  logic desc_last;
  logic np_pend;
  logic granted;
  logic [crd_pkg::RID_W-1:0] kept_rid;
  logic [crd_pkg::TAG_W-1:0] kept_tag;
  logic rx;

  assign rx = bus.creq_tvalid && bus.creq_tready;
  assign bus.creq_tready = (state == HS_DESC)
                           || (state == HS_PAY && (!pay_valid || pay_ready));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= HS_DESC;
      beat <= '0;
      desc_last <= 1'b0;
      rq_valid <= 1'b0;
      rq_desc <= '0;
      rq_fbe <= '0;
    end else begin
      case (state)
        HS_DESC: begin
          if (rx) begin
            if (beat[0]) begin
              rq_desc <= {bus.creq_tdata[crd_pkg::NARROW_DW-1:0],
                          rq_desc[crd_pkg::NARROW_DW-1:0]}; // RQ7
            end else begin
              rq_desc <= crd_pkg::DESC_W'(bus.creq_tdata);
            end
            if (beat == '0) begin
              rq_fbe <= bus.request_channel_sideband; // RQ10
            end
            if (beat == DESC_BEATS - 2'h1) begin
              beat <= '0;
              desc_last <= bus.creq_tlast;
              rq_valid <= 1'b1;
              state <= HS_HOLD;
            end else begin
              beat <= beat + 2'h1;
            end
          end
        end
        HS_HOLD: begin
          if (rq_ready) begin
            rq_valid <= 1'b0;
            state <= desc_last ? HS_DESC : HS_PAY;
          end
        end
        HS_PAY: begin
          if (rx && bus.creq_tlast) begin
            state <= HS_DESC;
          end
        end
        default: begin
          state <= HS_DESC;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pay_valid <= 1'b0;
      pay_data <= '0;
      pay_last <= 1'b0;
    end else if (state == HS_PAY && bus.creq_tready) begin
      pay_valid <= bus.creq_tvalid;
      if (bus.creq_tvalid) begin
        pay_data <= bus.creq_tdata;
        pay_last <= bus.creq_tlast;
      end
    end else if (pay_ready) begin
      pay_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Credit and completion return
  // ----------------------------------------------------------------------
  // One non-posted request is outstanding at most, so a single id and tag
  // store suffices; a new credit is granted only once its completion left.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      np_pend <= 1'b0;
      kept_rid <= '0;
      kept_tag <= '0;
    end else if (state == HS_HOLD && rq_ready && rq_np) begin
      np_pend <= 1'b1;
      kept_rid <= rq_desc[crd_pkg::RID_LSB +: crd_pkg::RID_W]; // RQ17
      kept_tag <= rq_desc[crd_pkg::TAG_LSB +: crd_pkg::TAG_W]; // RQ18
    end else if (cpl_valid && cpl_ready) begin
      np_pend <= 1'b0;
    end
  end

  assign cpl_ready = np_pend && !bus.ccpl_tvalid;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus.ccpl_tvalid <= 1'b0;
      bus.ccpl_tlast <= 1'b0;
      bus.ccpl_tdata <= '0;
    end else if (cpl_valid && cpl_ready) begin
      bus.ccpl_tvalid <= 1'b1;
      bus.ccpl_tlast <= 1'b1;
      bus.ccpl_tdata <= '0;
      bus.ccpl_tdata[crd_pkg::CPL_TAG_LSB +: crd_pkg::TAG_W] <= kept_tag; // RQ18
      bus.ccpl_tdata[crd_pkg::CPL_RID_LSB +: crd_pkg::RID_W] <= kept_rid; // RQ17
      bus.ccpl_tdata[crd_pkg::CPL_DATA_LSB +: crd_pkg::CPL_DATA_W] <= cpl_data;
    end else if (bus.ccpl_tready) begin
      bus.ccpl_tvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      granted <= 1'b0;
      bus.nonposted_credit_grant <= 1'b0;
    end else begin
      bus.nonposted_credit_grant <= 1'b0;
      if (!granted) begin
        granted <= 1'b1;
        bus.nonposted_credit_grant <= 1'b1; // RQ19
      end else if (bus.ccpl_tvalid && bus.ccpl_tready) begin
        bus.nonposted_credit_grant <= 1'b1; // RQ19
      end
    end
  end
endmodule : crd_user
`default_nettype wire

/* File: tb/crd_properties.sv */
// Concurrent checks on the signals between the two completer ends.
`timescale 1ns/1ns
`default_nettype none
module crd_properties #(
  parameter int DW = 64
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic creq_tvalid,
  input wire logic creq_tready,
  input wire logic creq_tlast,
  input wire logic [DW-1:0] creq_tdata,
  input wire logic nonposted_credit_grant,
  input wire logic ccpl_tvalid,
  input wire logic ccpl_tready,
  input wire logic ccpl_tlast,
  input wire logic [DW-1:0] ccpl_tdata
);
  // --------------------------------------------------------------------
  // Beat position
  // --------------------------------------------------------------------
  // Saturates at 2, so only the descriptor beats are told apart.
  logic [1:0] beat;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      beat <= 2'h0;
    end else if (creq_tvalid && creq_tready) begin
      beat <= creq_tlast ? 2'h0 : (beat == 2'h2 ? 2'h2 : beat + 2'h1);
    end
  end
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_cpl_take;
    ccpl_tvalid && ccpl_tready;
  endsequence
  sequence s_desc_hi;
    creq_tvalid && beat == 2'h1;
  endsequence
  AST_REQ_HOLD: assert property (
    creq_tvalid && !creq_tready |=> creq_tvalid && $stable(creq_tdata)
    && $stable(creq_tlast)) else $error("request beat moved while stalled");
  AST_CPL_HOLD: assert property (
    ccpl_tvalid && !ccpl_tready |=> ccpl_tvalid && $stable(ccpl_tdata))
    else $error("completion beat moved while stalled");
  AST_CPL_LAST: assert property (ccpl_tvalid |-> ccpl_tlast)
    else $error("completion beat without end mark");
  AST_CPL_GRANT: assert property (
    s_cpl_take |-> ##[1:2] nonposted_credit_grant)
    else $error("no credit after completion");
  AST_RST_GRANT: assert property (
    $rose(rst_b) |-> ##[0:2] nonposted_credit_grant)
    else $error("no credit after reset");
  AST_DESC_TWO: assert property (
    creq_tvalid && beat == 2'h0 && DW == 64 |-> !creq_tlast)
    else $error("narrow descriptor ended in one beat");
  AST_DESC_ZERO: assert property (
    s_desc_hi |-> DW != 64 || (creq_tdata[63:51] == 13'h0000
    && creq_tdata[47:40] == 8'h00 && !creq_tdata[15]))
    else $error("undefined descriptor bits set");
  AST_DW_COUNT: assert property (
    s_desc_hi |-> DW != 64 || creq_tdata[10:0] <= 11'h100)
    else $error("dword count above 256");
endmodule : crd_properties
`default_nettype wire

/* File: tb/completer_request_descriptor_test.sv */
// Self-checking bench joining the device end and the user end.
`timescale 1ns/1ns
`default_nettype none
module completer_request_descriptor_test;
  localparam int DW = 64;
  typedef struct {
    logic [127:0] d;
    logic [3:0] f;
    logic np;
  } crd_note_s;
  logic clock, rst_b, hdr_p_valid, hdr_p_ready, hdr_np_valid, hdr_np_ready;
  crd_pkg::crd_hdr_s hdr_p, hdr_np, pend, h;
  logic dpay_valid, dpay_last, dpay_ready, pay_from_np, cpl_valid, cpl_last;
  logic [DW-1:0] dpay_data, upay_data, cpl_data;
  logic cpl_ready, rq_valid, rq_np, rq_ready, upay_valid, upay_last;
  logic upay_ready, ucpl_valid, ucpl_ready, np_done;
  logic [127:0] rq_desc;
  logic [3:0] rq_fbe;
  logic [31:0] ucpl_data;
  int miscompares = 0;
  int checked = 0;
  crd_note_s dq[$];
  logic [64:0] pq[$];
  logic [63:0] cq[$];
  crd_note_s e;
  crd_if #(.DW(DW)) bus ();
  crd_device #(.DW(DW)) crd_device_i (.clock(clock), .rst_b(rst_b),
    .bus(bus), .hdr_p_valid(hdr_p_valid), .hdr_p(hdr_p),
    .hdr_p_ready(hdr_p_ready), .hdr_np_valid(hdr_np_valid),
    .hdr_np(hdr_np), .hdr_np_ready(hdr_np_ready), .pay_valid(dpay_valid),
    .pay_data(dpay_data), .pay_last(dpay_last), .pay_ready(dpay_ready),
    .pay_from_np(pay_from_np), .cpl_valid(cpl_valid), .cpl_data(cpl_data),
    .cpl_last(cpl_last), .cpl_ready(cpl_ready));
  crd_user #(.DW(DW)) crd_user_i (.clock(clock), .rst_b(rst_b), .bus(bus),
    .rq_valid(rq_valid), .rq_desc(rq_desc), .rq_fbe(rq_fbe), .rq_np(rq_np),
    .rq_ready(rq_ready), .pay_valid(upay_valid), .pay_data(upay_data),
    .pay_last(upay_last), .pay_ready(upay_ready), .cpl_valid(ucpl_valid),
    .cpl_data(ucpl_data), .cpl_ready(ucpl_ready));
  crd_properties #(.DW(DW)) crd_properties_i (.clock(clock), .rst_b(rst_b),
    .creq_tvalid(bus.creq_tvalid), .creq_tready(bus.creq_tready),
    .creq_tlast(bus.creq_tlast), .creq_tdata(bus.creq_tdata),
    .nonposted_credit_grant(bus.nonposted_credit_grant),
    .ccpl_tvalid(bus.ccpl_tvalid), .ccpl_tready(bus.ccpl_tready),
    .ccpl_tlast(bus.ccpl_tlast), .ccpl_tdata(bus.ccpl_tdata));
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic cmp(input logic [128:0] got, input logic [128:0] exp,
    input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic [127:0] exp_desc(crd_pkg::crd_hdr_s x);
    logic [127:0] d;
    d = '0;
    if (x.cls == crd_pkg::CLS_MEM) begin
      d[63:2] = x.addr[63:2];
      if (!x.addr64) d[63:32] = 32'h0000_0000;
      if (!x.io) d[1:0] = x.at;
      d[114:112] = x.bar;
    end
    d[74:64] = (x.io || x.zero_len) ? crd_pkg::CNT_ONE : x.len;
    d[78:75] = x.rtype;
    d[95:80] = x.rid;
    d[103:96] = x.tag;
    return d;
  endfunction : exp_desc
  function automatic crd_pkg::crd_hdr_s rnd(int c, logic np);
    logic [127:0] r;
    crd_pkg::crd_hdr_s x;
    r = {$urandom, $urandom, $urandom, $urandom};
    x = r[$bits(x)-1:0];
    x.cls = crd_pkg::crd_class_e'(c);
    x.posted = !np;
    x.io = 1'b0;
    x.zero_len = 1'b0;
    x.addr[1:0] = 2'h0;
    x.at = x.at == 2'h3 ? 2'h0 : x.at;
    x.len = 11'($urandom_range(256));
    return x;
  endfunction : rnd
  function automatic logic rdy(int k);
    return k == 0 ? hdr_p_ready : k == 1 ? hdr_np_ready :
      k == 2 ? dpay_ready : ucpl_ready;
  endfunction : rdy
  // Inputs are still only moved at falling edges; this only waits.
  task automatic hold(int k);
    #1;
    while (rdy(k) !== 1'b1) begin
      @(negedge clock);
      #1;
    end
    @(posedge clock);
  endtask : hold
  task automatic send_req(crd_pkg::crd_hdr_s x, int beats);
    x.has_pay = beats != 0;
    @(negedge clock);
    if (x.posted) begin
      hdr_p = x;
      hdr_p_valid = 1'b1;
    end else begin
      hdr_np = x;
      hdr_np_valid = 1'b1;
    end
    hold(x.posted ? 0 : 1);
    dq.push_back('{exp_desc(x), x.zero_len ? crd_pkg::FBE_NONE : x.fbe,
      !x.posted});
    if (!x.posted) pend = x;
    if (!x.posted) np_done = 1'b1;
    @(negedge clock);
    if (x.posted) hdr_p_valid = 1'b0;
    else hdr_np_valid = 1'b0;
    for (int i = 0; i < beats; i++) begin
      dpay_data = {$urandom, $urandom};
      dpay_last = i == beats - 1;
      dpay_valid = 1'b1;
      hold(2);
      pq.push_back({dpay_last, dpay_data});
      cmp(129'(pay_from_np), 129'(!x.posted), "np flag");
      @(negedge clock);
    end
    dpay_valid = 1'b0;
  endtask : send_req
  task automatic send_cpl();
    @(negedge clock);
    ucpl_data = $urandom;
    ucpl_valid = 1'b1;
    hold(3);
    cq.push_back({ucpl_data, 8'h00, pend.rid, pend.tag});
    @(negedge clock);
    ucpl_valid = 1'b0;
  endtask : send_cpl
  // --------------------------------------------------------------------
  // Far-side readiness and result watcher
  // --------------------------------------------------------------------
  always @(negedge clock) begin
    rq_ready <= $urandom_range(3) != 0;
    upay_ready <= $urandom_range(3) != 0;
    cpl_ready <= $urandom_range(3) != 0;
    rq_np <= dq.size() > 0 ? dq[0].np : 1'b0;
  end
  always @(posedge clock) begin
    if (rq_valid && rq_ready) begin
      e = dq.pop_front();
      cmp(129'(rq_desc), 129'(e.d), "descriptor");
      cmp(129'(rq_fbe), 129'(e.f), "byte enables");
    end
    if (upay_valid && upay_ready)
      cmp(129'({upay_last, upay_data}), 129'(pq.pop_front()), "payload");
    if (cpl_valid && cpl_ready)
      cmp(129'({cpl_last, cpl_data}), 129'({1'b1, cq.pop_front()}), "cpl");
  end
  initial begin
    #40000;
    miscompares++;
    tally_and_finish();
  end
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    {rst_b, hdr_p_valid, hdr_np_valid, dpay_valid, dpay_last} = 5'h00;
    {rq_ready, rq_np, upay_ready, ucpl_valid, cpl_ready} = 5'h00;
    {hdr_p, hdr_np, pend, dpay_data, ucpl_data} = '0;
    np_done = 1'b0;
    void'($urandom(60));
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    for (int c = 0; c < 4; c++) send_req(rnd(c, 1'b0), c);
    for (int a = 0; a < 3; a++) begin
      h = rnd(0, 1'b0);
      h.at = 2'(a);
      h.addr64 = a[0];
      send_req(h, 1);
    end
    h = rnd(0, 1'b0);
    h.len = 11'h100;
    send_req(h, 2);
    h = rnd(3, 1'b0);
    h.len = 11'h000;
    send_req(h, 0);
    h = rnd(0, 1'b1);
    h.zero_len = 1'b1;
    h.fbe = 4'hf;
    send_req(h, 0);
    send_cpl();
    h = rnd(0, 1'b1);
    h.io = 1'b1;
    send_req(h, 1);
    send_cpl();
    send_req(rnd(0, 1'b1), 0);
    np_done = 1'b0;
    fork
      send_req(rnd(0, 1'b1), 0);
      begin
        send_req(rnd(0, 1'b0), 8);
        cmp(129'(np_done), 129'(0), "np passed posted");
      end
      begin
        repeat (3) @(negedge clock);
        send_cpl();
      end
    join
    send_cpl();
    repeat (20) send_req(rnd($urandom_range(3), 1'b0), $urandom_range(3));
    repeat (200) @(negedge clock);
    cmp(129'(dq.size() + pq.size() + cq.size()), 129'(0), "left");
    tally_and_finish();
  end
endmodule : completer_request_descriptor_test
`default_nettype wire
